/* logic/prl_pkg.sv */
// Package for the per-port rate limiter: register map, fields, constants.
package prl_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] A_PORT_CTRL = 8'h00;
  localparam logic [7:0] A_RATE_CTRL = 8'h01;
  localparam logic [7:0] A_IN_CODE0 = 8'h02;
  localparam logic [7:0] A_EG_CODE0 = 8'h06;
  localparam logic [7:0] A_EB_CODE0 = 8'h0A;
  localparam logic [7:0] A_RATIO_LO = 8'h0E;
  localparam logic [7:0] A_RATIO_HI = 8'h0F;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_DROP_CNT = 8'h11;
  localparam logic [7:0] A_MAP_LO = 8'h80;
  localparam logic [7:0] A_MAP_HI = 8'h81;
  localparam logic [7:0] A_GLOBAL = 8'h87;

  // ==========================================================
  // Field positions
  localparam int F_QMODE = 0;
  localparam int F_PORT_PRIO = 3;
  localparam int F_PRIO_SRC = 5;
  localparam int F_IN_PPS = 0;
  localparam int F_EG_PPS = 1;
  localparam int F_CLS_SEL = 2;
  localparam int F_FC_EN = 4;
  localparam int F_EXTRA = 5;
  localparam int F_RATIO_EN = 0;
  localparam int F_QUEUE_EN = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PORT_CTRL = 8'h00;
  localparam logic [7:0] RST_RATE_CTRL = 8'h00;
  localparam logic [6:0] RST_CODE = 7'h00;
  localparam logic [7:0] RST_RATIO_LO = 8'h21;
  localparam logic [7:0] RST_RATIO_HI = 8'h84;
  localparam logic [7:0] RST_MAP_LO = 8'h50;
  localparam logic [7:0] RST_MAP_HI = 8'hFA;
  localparam logic [7:0] RST_GLOBAL = 8'h00;

  // ==========================================================
  // Timing and credit units
  // One tick is 125 us: 64 kbps is 8 bits a tick, 64 pps is 8 units a tick
  localparam int CLK_PS = 5000;
  localparam longint TICK_PS = 125000000;
  localparam int TICK_CYC = int'(TICK_PS / CLK_PS);
  localparam logic [19:0] PKT_COST = 20'h003E8;
  localparam logic signed [20:0] BURST = 21'sh04E20;
  localparam logic [6:0] CODE_COARSE_MAX = 7'h64;
  localparam logic [6:0] CODE_FINE_MAX = 7'h73;
  localparam logic [6:0] CODE_10M_MAX = 7'h0A;
  localparam logic [17:0] STEP_MBPS = 18'h0007D;
  localparam logic [17:0] STEP_KPPS = 18'h000F0;
  localparam logic [17:0] STEP_64K = 18'h00008;
  localparam logic [17:0] STEP_128P = 18'h00010;
  localparam logic [17:0] LAST_FINE_BPS = 18'h00079;
  localparam logic [11:0] IFG_BYTES = 12'h00C;
  localparam logic [11:0] PRE_BYTES = 12'h008;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b11
  } prl_speed_t;

  typedef enum logic [1:0] {
    CLS_UCAST = 2'b00,
    CLS_FLOOD = 2'b01,
    CLS_MCAST = 2'b10,
    CLS_BCAST = 2'b11
  } prl_cls_t;

  typedef struct packed {
    prl_cls_t cls;
    logic [2:0] pcp;
    logic [5:0] dscp;
    logic [11:0] len;
  } prl_rx_frm_t;

  typedef struct packed {
    logic [1:0] q;
    logic [11:0] len;
  } prl_tx_frm_t;

endpackage

/* logic/prl_limiter.sv */
// Per-port ingress and egress rate limiter with register port.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module prl_limiter #(
  parameter int TICK_CYC = prl_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire prl_pkg::prl_speed_t speed_i,
  input wire logic rx_vld_i,
  input wire prl_pkg::prl_rx_frm_t rx_frm_i,
  output logic rx_drop_o,
  output logic rx_pause_o,
  input wire logic tx_vld_i,
  input wire prl_pkg::prl_tx_frm_t tx_frm_i,
  output logic [3:0] tx_ok_o
);

  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 1048575) begin
      $error("TICK_CYC out of range");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [19:0] tick_cnt;
    logic [7:0] port_ctrl;
    logic [7:0] rate_ctrl;
    logic [3:0][6:0] in_code;
    logic [3:0][6:0] eg_code;
    logic [3:0][6:0] eb_code;
    logic [3:0][3:0] ratio;
    logic [7:0] map_lo;
    logic [7:0] map_hi;
    logic [7:0] glob;
    logic [3:0][19:0] in_cr;
    logic [3:0][19:0] eg_cr;
    logic [3:0][19:0] eb_cr;
    logic [7:0] drop_cnt;
    logic [7:0] rdata;
    logic drop;
    logic pause;
    logic [3:0] ok;
  } prl_state_t;

  prl_state_t st_q;
  prl_state_t st_d;

  // ==========================================================
  // Rate decode: credit units per tick, zero means unlimited
  function automatic logic [17:0] rate_f(input logic [6:0] code,
                                         input logic pps,
                                         input prl_pkg::prl_speed_t spd);
    logic [17:0] r;
    logic [17:0] n;
    r = '0;
    n = {11'h000, code} - 18'h00064;
    if (code == 7'h00) begin
      r = '0;
    end else if (code > prl_pkg::CODE_FINE_MAX) begin
      r = '0;
    // beyond 10M on a 10M port
    end else if (spd == prl_pkg::SPD_10 && code > prl_pkg::CODE_10M_MAX &&
                 code <= prl_pkg::CODE_COARSE_MAX) begin
      r = '0;
    end else if (code <= prl_pkg::CODE_COARSE_MAX) begin
      r = 18'((pps ? prl_pkg::STEP_KPPS : prl_pkg::STEP_MBPS) *
              {11'h000, code});
    end else if (pps) begin
      // first step 64 pps, then 128 pps
      r = (n == 18'h00001) ? prl_pkg::STEP_64K :
          18'(prl_pkg::STEP_128P * (n - 18'h00001));
    end else begin
      // 64 kbps steps below one megabit
      r = (code == prl_pkg::CODE_FINE_MAX) ? prl_pkg::LAST_FINE_BPS :
          18'(prl_pkg::STEP_64K * n);
    end
    if (spd == prl_pkg::SPD_1000) begin
      r = 18'(r * 18'h0000A);
    end
    return r;
  endfunction

  function automatic logic [19:0] bucket_f(input logic [19:0] cr,
                                           input logic [17:0] rate,
                                           input logic tick,
                                           input logic take,
                                           input logic [19:0] cost);
    logic signed [20:0] n;
    logic signed [20:0] cap;
    n = $signed({cr[19], cr});
    cap = $signed({3'b000, rate}) + prl_pkg::BURST;
    if (rate == 18'h00000) begin
      n = '0;
    end else begin
      if (tick) begin
        n = n + $signed({3'b000, rate});
        if (n > cap) begin
          n = cap;
        end
      end
      if (take) begin
        n = n - $signed({1'b0, cost});
      end
    end
    return n[19:0];
  endfunction

  // ==========================================================
  // Queue selection
  logic multi_q;
  logic four_q;
  logic [1:0] top_q;
  logic [1:0] prio_src;
  logic [2:0] prio_idx;
  logic [1:0] rx_prio;
  logic [1:0] rx_q;
  logic [1:0] tx_q;
  logic tick;

  // queues split only with global enable
  assign multi_q = st_q.glob[prl_pkg::F_QUEUE_EN] &&
                   st_q.port_ctrl[prl_pkg::F_QMODE +: 2] != 2'b00;
  assign four_q = st_q.port_ctrl[prl_pkg::F_QMODE +: 2] == 2'b10;
  assign top_q = four_q ? 2'd3 : 2'd1;
  assign prio_src = st_q.port_ctrl[prl_pkg::F_PRIO_SRC +: 2];
  assign tick = st_q.tick_cnt == 20'(TICK_CYC - 1);

  // fixed port priority or frame priority
  always_comb begin
    prio_idx = (prio_src == 2'b10) ? rx_frm_i.dscp[5:3] : rx_frm_i.pcp;
    if (prio_src == 2'b00) begin
      rx_prio = st_q.port_ctrl[prl_pkg::F_PORT_PRIO +: 2];
    // remap through the two map registers
    end else if (prio_idx[2]) begin
      rx_prio = st_q.map_hi[{prio_idx[1:0], 1'b0} +: 2];
    end else begin
      rx_prio = st_q.map_lo[{prio_idx[1:0], 1'b0} +: 2];
    end
  end

  function automatic logic [1:0] qsel_f(input logic [1:0] p,
                                        input logic multi,
                                        input logic four);
    logic [1:0] q;
    q = 2'd0;
    // four fields, or first two fields
    if (multi) begin
      q = four ? p : {1'b0, p != 2'd0};
    end
    return q;
  endfunction

  assign rx_q = qsel_f(rx_prio, multi_q, four_q);
  assign tx_q = qsel_f(tx_frm_i.q, multi_q, four_q);

  // ==========================================================
  // Per-queue rates and frame costs
  logic [3:0][17:0] in_rate;
  logic [3:0][17:0] eg_rate;
  logic [3:0][17:0] eb_rate;
  logic [17:0] eg_top;
  logic [19:0] rx_bits;
  logic [19:0] tx_bits;
  logic [11:0] extra;

  assign eg_top = rate_f(st_q.eg_code[top_q],
                         st_q.rate_ctrl[prl_pkg::F_EG_PPS], speed_i);

  // frame bytes plus configured IFG or preamble
  always_comb begin
    unique case (st_q.rate_ctrl[prl_pkg::F_EXTRA +: 2])
      2'b01: extra = prl_pkg::IFG_BYTES;
      2'b10: extra = prl_pkg::PRE_BYTES;
      2'b11: extra = prl_pkg::IFG_BYTES + prl_pkg::PRE_BYTES;
      default: extra = 12'h000;
    endcase
  end
  assign rx_bits = {5'b00000, rx_frm_i.len + extra, 3'b000};
  assign tx_bits = {5'b00000, tx_frm_i.len + extra, 3'b000};

  // one ingress and two egress rates (rate and bit bound) per queue
  for (genvar i = 0; i < 4; i++) begin : g_rate
    logic [21:0] scaled;
    assign scaled = eg_top * st_q.ratio[i];
    assign in_rate[i] = rate_f(st_q.in_code[i],
                               st_q.rate_ctrl[prl_pkg::F_IN_PPS], speed_i);
    // lower queues follow ratio of top queue
    assign eg_rate[i] = (st_q.glob[prl_pkg::F_RATIO_EN] && multi_q &&
                         2'(i) < top_q) ? scaled[20:3] :
                        rate_f(st_q.eg_code[i],
                               st_q.rate_ctrl[prl_pkg::F_EG_PPS], speed_i);
    // bit bound of packet rate, egress only
    assign eb_rate[i] = st_q.rate_ctrl[prl_pkg::F_EG_PPS] ?
                        rate_f(st_q.eb_code[i], 1'b0, speed_i) : 18'h00000;
  end

  // ==========================================================
  // Next state
  logic cls_hit;
  logic rx_over;
  logic rx_take;
  logic fc_en;
  logic [3:0] in_neg;
  logic [3:0] ok_n;

  always_comb begin
    unique case (st_q.rate_ctrl[prl_pkg::F_CLS_SEL +: 2])
      2'b00: cls_hit = 1'b1;
      2'b01: cls_hit = rx_frm_i.cls != prl_pkg::CLS_UCAST;
      2'b10: cls_hit = rx_frm_i.cls[1];
      default: cls_hit = rx_frm_i.cls == prl_pkg::CLS_BCAST;
    endcase
  end

  assign fc_en = st_q.rate_ctrl[prl_pkg::F_FC_EN];
  assign rx_over = st_q.in_cr[rx_q][19] && in_rate[rx_q] != 18'h00000;
  // drop over limit unless flow control on
  assign rx_take = rx_vld_i && cls_hit && !(rx_over && !fc_en);

  always_comb begin
    st_d = st_q;
    st_d.tick_cnt = tick ? 20'h00000 : st_q.tick_cnt + 20'h00001;
    st_d.drop = 1'b0;
    st_d.rdata = 8'h00;
    in_neg = 4'h0;
    ok_n = 4'h0;

    // receive and transmit buckets kept apart
    for (int i = 0; i < 4; i++) begin
      st_d.in_cr[i] = bucket_f(st_q.in_cr[i], in_rate[i], tick,
                               rx_take && rx_q == 2'(i),
                               st_q.rate_ctrl[prl_pkg::F_IN_PPS] ?
                               prl_pkg::PKT_COST : rx_bits);
      st_d.eg_cr[i] = bucket_f(st_q.eg_cr[i], eg_rate[i], tick,
                               tx_vld_i && tx_q == 2'(i),
                               st_q.rate_ctrl[prl_pkg::F_EG_PPS] ?
                               prl_pkg::PKT_COST : tx_bits);
      st_d.eb_cr[i] = bucket_f(st_q.eb_cr[i], eb_rate[i], tick,
                               tx_vld_i && tx_q == 2'(i), tx_bits);
      in_neg[i] = st_d.in_cr[i][19];
    end

    // queue waits while its credit is owed
    for (int i = 0; i < 4; i++) begin
      ok_n[i] = !st_d.eg_cr[qsel_f(2'(i), multi_q, four_q)][19] &&
                !st_d.eb_cr[qsel_f(2'(i), multi_q, four_q)][19];
    end
    st_d.ok = ok_n;

    if (rx_vld_i && cls_hit && rx_over && !fc_en) begin
      st_d.drop = 1'b1;
      st_d.drop_cnt = st_q.drop_cnt + 8'h01;
    end
    st_d.pause = fc_en && |in_neg;

    if (wr_i) begin
      unique case (addr_i)
        prl_pkg::A_PORT_CTRL: st_d.port_ctrl = wdata_i;
        prl_pkg::A_RATE_CTRL: st_d.rate_ctrl = wdata_i;
        prl_pkg::A_RATIO_LO: st_d.ratio[1:0] = wdata_i;
        prl_pkg::A_RATIO_HI: st_d.ratio[3:2] = wdata_i;
        prl_pkg::A_MAP_LO: st_d.map_lo = wdata_i;
        prl_pkg::A_MAP_HI: st_d.map_hi = wdata_i;
        prl_pkg::A_GLOBAL: st_d.glob = wdata_i;
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr_i == prl_pkg::A_IN_CODE0 + 8'(i)) begin
              st_d.in_code[i] = wdata_i[6:0];
            end
            if (addr_i == prl_pkg::A_EG_CODE0 + 8'(i)) begin
              st_d.eg_code[i] = wdata_i[6:0];
            end
            if (addr_i == prl_pkg::A_EB_CODE0 + 8'(i)) begin
              st_d.eb_code[i] = wdata_i[6:0];
            end
          end
        end
      endcase
    end

    if (rd_i) begin
      unique case (addr_i)
        prl_pkg::A_PORT_CTRL: st_d.rdata = st_q.port_ctrl;
        prl_pkg::A_RATE_CTRL: st_d.rdata = st_q.rate_ctrl;
        prl_pkg::A_RATIO_LO: st_d.rdata = st_q.ratio[1:0];
        prl_pkg::A_RATIO_HI: st_d.rdata = st_q.ratio[3:2];
        prl_pkg::A_STATUS: st_d.rdata = {in_neg_q(st_q.in_cr), st_q.ok};
        prl_pkg::A_DROP_CNT: st_d.rdata = st_q.drop_cnt;
        prl_pkg::A_MAP_LO: st_d.rdata = st_q.map_lo;
        prl_pkg::A_MAP_HI: st_d.rdata = st_q.map_hi;
        prl_pkg::A_GLOBAL: st_d.rdata = st_q.glob;
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr_i == prl_pkg::A_IN_CODE0 + 8'(i)) begin
              st_d.rdata = {1'b0, st_q.in_code[i]};
            end
            if (addr_i == prl_pkg::A_EG_CODE0 + 8'(i)) begin
              st_d.rdata = {1'b0, st_q.eg_code[i]};
            end
            if (addr_i == prl_pkg::A_EB_CODE0 + 8'(i)) begin
              st_d.rdata = {1'b0, st_q.eb_code[i]};
            end
          end
        end
      endcase
    end
  end

  // Sign bits of the ingress buckets, for the status register
  function automatic logic [3:0] in_neg_q(input logic [3:0][19:0] cr);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 4; i++) begin
      s[i] = cr[i][19];
    end
    return s;
  endfunction

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
      st_q.port_ctrl <= prl_pkg::RST_PORT_CTRL;
      st_q.rate_ctrl <= prl_pkg::RST_RATE_CTRL;
      st_q.in_code <= {4{prl_pkg::RST_CODE}};
      st_q.eg_code <= {4{prl_pkg::RST_CODE}};
      st_q.eb_code <= {4{prl_pkg::RST_CODE}};
      st_q.ratio <= {prl_pkg::RST_RATIO_HI, prl_pkg::RST_RATIO_LO};
      st_q.map_lo <= prl_pkg::RST_MAP_LO;
      st_q.map_hi <= prl_pkg::RST_MAP_HI;
      st_q.glob <= prl_pkg::RST_GLOBAL;
      st_q.ok <= 4'hF;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign rx_drop_o = st_q.drop;
  assign rx_pause_o = st_q.pause;
  assign tx_ok_o = st_q.ok;

endmodule

`default_nettype wire

/* tb/prl_limiter_properties.sv */
// Port-level assertions for the per-port rate limiter.
`timescale 1ns/1ps
`default_nettype none
module prl_limiter_chk #(
  parameter int TICK_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire prl_pkg::prl_speed_t speed_i,
  input wire logic rx_vld_i,
  input wire prl_pkg::prl_rx_frm_t rx_frm_i,
  input wire logic rx_drop_o,
  input wire logic rx_pause_o,
  input wire logic tx_vld_i,
  input wire prl_pkg::prl_tx_frm_t tx_frm_i,
  input wire logic [3:0] tx_ok_o
);
  // ==========================================================
  // Shadow of the settings software wrote
  logic [7:0] rate_q;
  logic [3:0][6:0] code_q;
  logic lim_w;
  logic cnt_w;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rate_q <= 8'h00;
      code_q <= '0;
    end else if (wr_i) begin
      if (addr_i == prl_pkg::A_RATE_CTRL) begin
        rate_q <= wdata_i;
      end
      if (addr_i inside {[prl_pkg::A_IN_CODE0:8'h05]}) begin
        code_q[addr_i[1:0] - 2'h2] <= wdata_i[6:0];
      end
    end
  end
  // Superset: any limiting ingress code, whatever the queue mode
  always_comb begin
    lim_w = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (code_q[i] != 7'h00 && code_q[i] <= prl_pkg::CODE_FINE_MAX &&
          !(speed_i == prl_pkg::SPD_10 &&
            code_q[i] > prl_pkg::CODE_10M_MAX &&
            code_q[i] <= prl_pkg::CODE_COARSE_MAX)) begin
        lim_w = 1'b1;
      end
    end
    case (rate_q[3:2])
      2'b00: cnt_w = 1'b1;
      2'b01: cnt_w = rx_frm_i.cls != prl_pkg::CLS_UCAST;
      2'b10: cnt_w = rx_frm_i.cls[1];
      default: cnt_w = rx_frm_i.cls == prl_pkg::CLS_BCAST;
    endcase
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  drop_after_frame_a: assert property (rx_drop_o |-> $past(rx_vld_i))
    else $error("drop without a frame");
  fc_no_drop_a: assert property (rx_drop_o |-> !$past(rate_q[4]))
    else $error("drop while flow control on");
  pause_needs_fc_a: assert property (
    rx_pause_o |-> rate_q[4] || $past(rate_q[4]))
    else $error("pause while flow control off");
  class_filter_a: assert property (rx_drop_o |-> $past(cnt_w))
    else $error("drop of an unselected class");
  unlimited_pass_a: assert property (rx_drop_o |-> $past(lim_w))
    else $error("drop with no limiting code");
  ok_fall_cause_a: assert property (
    |($past(tx_ok_o) & ~tx_ok_o) |-> $past(tx_vld_i))
    else $error("queue stopped with no frame sent");
  code_bit7_zero_a: assert property (
    rd_i && addr_i inside {[prl_pkg::A_IN_CODE0:8'h0D]} |=> !rdata_o[7])
    else $error("code register bit 7 set");
  rate_readback_a: assert property (
    rd_i && addr_i == prl_pkg::A_RATE_CTRL |=>
      rdata_o[6:0] == $past(rate_q[6:0]))
    else $error("rate control readback wrong");
  drop_seen_c: cover property (rx_drop_o);
  pause_seen_c: cover property (rx_pause_o);
  shaped_c: cover property (tx_ok_o != 4'hF);
endmodule
bind prl_limiter prl_limiter_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .speed_i(speed_i), .rx_vld_i(rx_vld_i), .rx_frm_i(rx_frm_i),
  .rx_drop_o(rx_drop_o), .rx_pause_o(rx_pause_o), .tx_vld_i(tx_vld_i),
  .tx_frm_i(tx_frm_i), .tx_ok_o(tx_ok_o));
`default_nettype wire

/* tb/prl_mac_model.sv */
// Transmit MAC and queue model that waits for per-queue permission.
`timescale 1ns/1ps
`default_nettype none
module prl_mac_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic [1:0] q_i,
  input wire logic [11:0] len_i,
  input wire logic [3:0] tx_ok_i,
  output logic tx_vld_o,
  output var prl_pkg::prl_tx_frm_t tx_frm_o,
  output logic [15:0] sent_o
);
  // held frames wait in the queue; one idle cycle lets ok settle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_vld_o <= 1'b0;
      tx_frm_o <= '0;
      sent_o <= 16'h0000;
    end else if (go_i && !tx_vld_o && tx_ok_i[q_i]) begin
      tx_vld_o <= 1'b1;
      tx_frm_o <= '{q: q_i, len: len_i};
      sent_o <= sent_o + 16'h0001;
    end else begin
      tx_vld_o <= 1'b0;
      // Idle descriptor carries no meaning, so keep it moving
      tx_frm_o <= ~tx_frm_o;
    end
  end
endmodule
`default_nettype wire

/* tb/port_rate_limiter_tb_top.sv */
// Self-checking bench for the per-port rate limiter.
`timescale 1ns/1ps
`default_nettype none
module port_rate_limiter_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rx_vld = 1'b0;
  logic go = 1'b0;
  logic [1:0] mq = 2'h0;
  prl_pkg::prl_speed_t speed = prl_pkg::SPD_100;
  prl_pkg::prl_rx_frm_t rx_frm = '0;
  prl_pkg::prl_tx_frm_t tx_frm;
  logic [7:0] rdata;
  logic rx_drop, rx_pause, tx_vld, rd_seen, rx_seen;
  logic [3:0] tx_ok;
  logic [15:0] sent, s0;
  logic [7:0] rd_exp[$];
  logic [1:0] rx_exp[$];
  logic [31:0] seed = 32'hBA52;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  prl_limiter #(.TICK_CYC(20)) DUT (
    .sys_clk_i(sys_clk), .nrst_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .speed_i(speed),
    .rx_vld_i(rx_vld), .rx_frm_i(rx_frm), .rx_drop_o(rx_drop),
    .rx_pause_o(rx_pause), .tx_vld_i(tx_vld), .tx_frm_i(tx_frm),
    .tx_ok_o(tx_ok));
  prl_mac_model u_mac (
    .sys_clk_i(sys_clk), .nrst_i(rst_n), .go_i(go), .q_i(mq),
    .len_i(12'h5DC), .tx_ok_i(tx_ok), .tx_vld_o(tx_vld),
    .tx_frm_o(tx_frm), .sent_o(sent));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    rd_exp.push_back(e);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask
  // Expectation is {care, dropped}; frames go back to back
  task automatic rx(input logic [1:0] c, input logic [2:0] p,
                    input logic [1:0] e);
    @(posedge sys_clk);
    seed = xs(seed);
    rx_vld <= 1'b1;
    rx_frm <= '{cls: prl_pkg::prl_cls_t'(c), pcp: p, dscp: seed[5:0],
                len: 12'h5DC};
    rx_exp.push_back(e);
  endtask
  task automatic rx_end();
    @(posedge sys_clk);
    rx_vld <= 1'b0;
  endtask
  // ==========================================================
  // Result watcher and hang guard
  always @(posedge sys_clk) begin
    logic [1:0] e;
    if (rd_seen === 1'b1) begin
      chk(rd_exp.pop_front(), rdata);
    end
    if (rx_seen === 1'b1) begin
      e = rx_exp.pop_front();
      if (e[1]) begin
        chk({7'h00, e[0]}, {7'h00, rx_drop});
      end
    end
    rd_seen = rd;
    rx_seen = rx_vld;
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      close_out();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rreg(prl_pkg::A_RATIO_LO, 8'h21);
    rreg(prl_pkg::A_RATIO_HI, 8'h84);
    rreg(prl_pkg::A_MAP_LO, prl_pkg::RST_MAP_LO);
    rreg(prl_pkg::A_MAP_HI, prl_pkg::RST_MAP_HI);
    rreg(prl_pkg::A_GLOBAL, 8'h00);
    rreg(8'h55, 8'h00);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      wreg(prl_pkg::A_IN_CODE0 + 8'(i), seed[7:0]);
      rreg(prl_pkg::A_IN_CODE0 + 8'(i), {1'b0, seed[6:0]});
    end
    // Second reset restores unlimited codes; the last read is seen first
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rreg(prl_pkg::A_IN_CODE0 + 8'h03, 8'h00);
    // four queues, priority from the frame tag
    wreg(prl_pkg::A_PORT_CTRL, 8'h22);
    wreg(prl_pkg::A_GLOBAL, 8'h08);
    wreg(prl_pkg::A_IN_CODE0 + 8'h03, 8'h65);
    for (int i = 0; i < 4; i++) rx(2'h0, 3'h0, 2'b10);
    for (int i = 0; i < 4; i++) rx(2'h0, 3'h7, (i > 1) ? 2'b11 : 2'b00);
    rx_end();
    wreg(prl_pkg::A_RATE_CTRL, 8'h0C);
    rx(2'h0, 3'h7, 2'b10);
    rx(2'h3, 3'h7, 2'b11);
    rx_end();
    wreg(prl_pkg::A_RATE_CTRL, 8'h10);
    rx(2'h3, 3'h7, 2'b10);
    rx_end();
    chk(8'h01, {7'h00, rx_pause});
    rreg(prl_pkg::A_RATE_CTRL, 8'h10);
    rreg(prl_pkg::A_STATUS, 8'h8F);
    wreg(prl_pkg::A_RATE_CTRL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      speed <= (i == 0) ? prl_pkg::SPD_10 : prl_pkg::SPD_100;
      wreg(prl_pkg::A_IN_CODE0 + 8'h03,
           (i == 0) ? 8'h32 : ((i == 1) ? 8'h74 : 8'h00));
      repeat (25) @(posedge sys_clk);
      for (int j = 0; j < 3; j++) rx(2'h3, 3'h7, 2'b10);
      rx_end();
    end
    // Fixed port priority 3 sends untagged frames to the limited Q3
    wreg(prl_pkg::A_PORT_CTRL, 8'h1A);
    wreg(prl_pkg::A_IN_CODE0 + 8'h03, 8'h65);
    rx(2'h3, 3'h0, 2'b10);
    rx(2'h3, 3'h0, 2'b11);
    rx_end();
    // Two queues: priority 3 lands on the unlimited Q1, not on Q3
    wreg(prl_pkg::A_PORT_CTRL, 8'h21);
    rx(2'h3, 3'h7, 2'b10);
    rx_end();
    wreg(prl_pkg::A_PORT_CTRL, 8'h22);
    rreg(prl_pkg::A_DROP_CNT, 8'h05);
    // Egress: 1 Mbps on Q0 lets at most three long frames out
    wreg(prl_pkg::A_EG_CODE0, 8'h01);
    go <= 1'b1;
    repeat (2000) @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(8'h01, {7'h00, sent >= 16'h0001 && sent <= 16'h0003});
    s0 = sent;
    // Q1 egress left unlimited, above any ingress limit
    mq <= 2'h1;
    go <= 1'b1;
    repeat (200) @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
    s0 = sent - s0;
    chk(8'h01, {7'h00, s0 >= 16'd99 && s0 <= 16'd101});
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule
`default_nettype wire
